//--- core/tis_params.svh
`ifndef TIS_PARAMS_SVH
`define TIS_PARAMS_SVH
`define TIS_IR_W          3
`define TIS_IR_CAPTURE    3'h4
`define TIS_IR_IDCODE     3'h1
`define TIS_IR_BYPASS     3'h7
`define TIS_IR_EXTEST     3'h0
`define TIS_IR_SAMPLE     3'h2
`define TIS_BSR_W         8
`define TIS_ID_W          32
// identification value is arbitrary
`define TIS_ID_VALUE      32'h1234_5679
`define TIS_RESET_ONES    5
`endif

//--- core/tis_pkg.sv
`default_nettype none
`include "tis_params.svh"
package tis_pkg;
    typedef enum logic [3:0] {
        TIS_RESET, TIS_IDLE, TIS_SEL_DR, TIS_CAP_DR, TIS_SHIFT_DR, TIS_EXIT1_DR,
        TIS_PAUSE_DR, TIS_EXIT2_DR, TIS_UPD_DR, TIS_SEL_IR, TIS_CAP_IR,
        TIS_SHIFT_IR, TIS_EXIT1_IR, TIS_PAUSE_IR, TIS_EXIT2_IR, TIS_UPD_IR
    } tis_state_e;
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tis_pins_s;
    typedef struct packed {
        logic rise;
        logic fall;
        logic tms;
        logic tdi;
    } tis_edge_s;
endpackage
`default_nettype wire

//--- core/tis_sync.sv
`default_nettype none
// two-flop synchroniser per pin, then tck edge detect on the second stage only
module tis_sync (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire tis_pkg::tis_pins_s pins,
    output var  tis_pkg::tis_edge_s ev
);
    import tis_pkg::*;
    tis_pins_s meta_q;
    tis_pins_s sync_q;
    logic      tck_old_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q    <= '0;
            sync_q    <= '0;
            tck_old_q <= 1'b0;
        end else begin
            meta_q    <= pins;
            sync_q    <= meta_q;
            tck_old_q <= sync_q.tck;
        end
    end
    // tms/tdi are sampled together with the tck edge, giving the setup a tester expects
    assign ev.rise = sync_q.tck & ~tck_old_q;
    assign ev.fall = ~sync_q.tck & tck_old_q;
    assign ev.tms  = sync_q.tms;
    assign ev.tdi  = sync_q.tdi;
endmodule
`default_nettype wire

//--- core/tis_tap.sv
// Contract
// - Exit1-IR goes to Update-IR if mode-select high, else Pause-IR.
// - Pause-IR holds while mode-select stays low.
// - Pause-IR moves to Exit2-IR on mode-select high.
// - Exit2-IR goes to Update-IR if high, back to Shift-IR if low.
// - instruction shift register holds its contents during Pause-IR.
// - Update-IR copies shift register to instruction output on falling edge.
// - latched instruction becomes active and selects the data register.
// - selected data register keeps its value in Exit1/Pause/Exit2/Update-IR.
// - active instruction changes only in Update-IR, or to IDCODE in the reset state.
// - Shift-IR goes to Exit1-IR on high, keeps shifting on low.
// - Capture-IR loads fixed pattern 100 into the shift register.
`default_nettype none
`include "tis_params.svh"
module tis_tap (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire tis_pkg::tis_pins_s        pins,
    input  wire logic [`TIS_BSR_W-1:0]     bsr_pins,
    output logic                           tdo,
    output logic                           tdo_oe,
    output var  tis_pkg::tis_state_e       state,
    output logic [`TIS_IR_W-1:0]           instr,
    output logic [`TIS_BSR_W-1:0]          bsr_out
);
    import tis_pkg::*;
    tis_edge_s               ev;
    tis_state_e              st_q;
    tis_state_e              st_d;
    logic [`TIS_IR_W-1:0]    irs_q;
    logic [`TIS_IR_W-1:0]    ir_q;
    logic [`TIS_BSR_W-1:0]   bsr_q;
    logic [`TIS_BSR_W-1:0]   bsr_upd_q;
    logic [`TIS_ID_W-1:0]    id_q;
    logic                    byp_q;
    logic                    tdo_q;
    logic                    oe_q;

    tis_sync u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .pins  (pins),
        .ev    (ev)
    );

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            TIS_RESET:    st_d = ev.tms ? TIS_RESET : TIS_IDLE;
            TIS_IDLE:     st_d = ev.tms ? TIS_SEL_DR : TIS_IDLE;
            TIS_SEL_DR:   st_d = ev.tms ? TIS_SEL_IR : TIS_CAP_DR;
            TIS_CAP_DR:   st_d = ev.tms ? TIS_EXIT1_DR : TIS_SHIFT_DR;
            TIS_SHIFT_DR: st_d = ev.tms ? TIS_EXIT1_DR : TIS_SHIFT_DR;
            TIS_EXIT1_DR: st_d = ev.tms ? TIS_UPD_DR : TIS_PAUSE_DR;
            TIS_PAUSE_DR: st_d = ev.tms ? TIS_EXIT2_DR : TIS_PAUSE_DR;
            TIS_EXIT2_DR: st_d = ev.tms ? TIS_UPD_DR : TIS_SHIFT_DR;
            TIS_UPD_DR:   st_d = ev.tms ? TIS_SEL_DR : TIS_IDLE;
            TIS_SEL_IR:   st_d = ev.tms ? TIS_RESET : TIS_CAP_IR;
            TIS_CAP_IR:   st_d = ev.tms ? TIS_EXIT1_IR : TIS_SHIFT_IR;
            TIS_SHIFT_IR: st_d = ev.tms ? TIS_EXIT1_IR : TIS_SHIFT_IR;
            TIS_EXIT1_IR: st_d = ev.tms ? TIS_UPD_IR : TIS_PAUSE_IR;
            TIS_PAUSE_IR: st_d = ev.tms ? TIS_EXIT2_IR : TIS_PAUSE_IR;
            TIS_EXIT2_IR: st_d = ev.tms ? TIS_UPD_IR : TIS_SHIFT_IR;
            TIS_UPD_IR:   st_d = ev.tms ? TIS_SEL_DR : TIS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= TIS_RESET;
        end else if (ev.rise) begin
            st_q <= st_d;
        end
    end
    assign state = st_q;

    // instruction shift path; any state not listed holds it, so Pause-IR freezes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irs_q <= `TIS_IR_CAPTURE;
        end else if (ev.rise) begin
            if (st_q == TIS_CAP_IR) begin
                irs_q <= `TIS_IR_CAPTURE;
            end else if (st_q == TIS_SHIFT_IR) begin
                irs_q <= {ev.tdi, irs_q[`TIS_IR_W-1:1]};
            end
        end
    end

    // parallel instruction latch on the falling tck edge in Update-IR; the reset state forces IDCODE on any clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_q <= `TIS_IR_IDCODE;
        end else if (st_q == TIS_RESET) begin
            ir_q <= `TIS_IR_IDCODE;
        end else if (ev.fall && st_q == TIS_UPD_IR) begin
            ir_q <= irs_q;
        end
    end
    assign instr = ir_q;

    // data registers move only in DR capture/shift, so every IR state leaves them alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bsr_q <= '0;
            id_q  <= `TIS_ID_VALUE;
            byp_q <= 1'b0;
        end else if (ev.rise) begin
            if (st_q == TIS_CAP_DR) begin
                unique case (ir_q)
                    `TIS_IR_EXTEST, `TIS_IR_SAMPLE: bsr_q <= bsr_pins;
                    `TIS_IR_IDCODE: id_q  <= `TIS_ID_VALUE;
                    default:        byp_q <= 1'b0;
                endcase
            end else if (st_q == TIS_SHIFT_DR) begin
                unique case (ir_q)
                    `TIS_IR_EXTEST, `TIS_IR_SAMPLE:
                        bsr_q <= {ev.tdi, bsr_q[`TIS_BSR_W-1:1]};
                    `TIS_IR_IDCODE: id_q <= {ev.tdi, id_q[`TIS_ID_W-1:1]};
                    default:        byp_q <= ev.tdi;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bsr_upd_q <= '0;
        end else if (ev.fall && st_q == TIS_UPD_DR &&
                     (ir_q == `TIS_IR_EXTEST || ir_q == `TIS_IR_SAMPLE)) begin
            bsr_upd_q <= bsr_q;
        end
    end
    assign bsr_out = bsr_upd_q;

    // tdo changes on the falling edge so the tester samples it stable on the rise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_q <= 1'b0;
            oe_q  <= 1'b0;
        end else if (ev.fall) begin
            oe_q  <= (st_q == TIS_SHIFT_IR) || (st_q == TIS_SHIFT_DR);
            if (st_q == TIS_SHIFT_IR) begin
                tdo_q <= irs_q[0];
            end else if (ir_q == `TIS_IR_EXTEST || ir_q == `TIS_IR_SAMPLE) begin
                tdo_q <= bsr_q[0];
            end else if (ir_q == `TIS_IR_IDCODE) begin
                tdo_q <= id_q[0];
            end else begin
                tdo_q <= byp_q;
            end
        end
    end
    assign tdo    = tdo_q;
    assign tdo_oe = oe_q;

    // exit1-ir is left only on a synced tck rise, never between edges
    property p_exit1;
        @(posedge clk) disable iff (!rst_n)
        (!ev.rise && st_q == TIS_EXIT1_IR) |=> st_q == TIS_EXIT1_IR;
    endproperty
    a_exit1: assert property (p_exit1) else $error("exit1-ir left without tck rise");

    property p_exit1_path;
        @(posedge clk) disable iff (!rst_n)
        (ev.rise && st_q == TIS_EXIT1_IR) |=>
            ($past(ev.tms) ? st_q == TIS_UPD_IR : st_q == TIS_PAUSE_IR);
    endproperty
    a_exit1_path: assert property (p_exit1_path) else $error("exit1-ir path");

    property p_pause_hold;
        @(posedge clk) disable iff (!rst_n)
        (ev.rise && st_q == TIS_PAUSE_IR && !ev.tms) |=> st_q == TIS_PAUSE_IR;
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("left pause-ir");

    property p_pause_exit;
        @(posedge clk) disable iff (!rst_n)
        (ev.rise && st_q == TIS_PAUSE_IR && ev.tms) |=> st_q == TIS_EXIT2_IR;
    endproperty
    a_pause_exit: assert property (p_pause_exit) else $error("no exit2-ir");

    property p_exit2;
        @(posedge clk) disable iff (!rst_n)
        (ev.rise && st_q == TIS_EXIT2_IR) |=>
            ($past(ev.tms) ? st_q == TIS_UPD_IR : st_q == TIS_SHIFT_IR);
    endproperty
    a_exit2: assert property (p_exit2) else $error("exit2-ir path");

    property p_ir_frozen;
        @(posedge clk) disable iff (!rst_n)
        (st_q == TIS_PAUSE_IR && $past(st_q) == TIS_PAUSE_IR) |-> $stable(irs_q);
    endproperty
    a_ir_frozen: assert property (p_ir_frozen) else $error("shift moved in pause");

    property p_update;
        @(posedge clk) disable iff (!rst_n)
        (ev.fall && st_q == TIS_UPD_IR) |=> ir_q == $past(irs_q);
    endproperty
    a_update: assert property (p_update) else $error("instruction not latched");

    property p_instr_only_update;
        @(posedge clk) disable iff (!rst_n)
        !$stable(ir_q) |-> $past(st_q) == TIS_UPD_IR || $past(st_q) == TIS_RESET;
    endproperty
    a_instr_only_update: assert property (p_instr_only_update)
        else $error("instruction changed outside update");

    property p_dr_hold;
        @(posedge clk) disable iff (!rst_n)
        (st_q inside {TIS_EXIT1_IR, TIS_PAUSE_IR, TIS_EXIT2_IR, TIS_UPD_IR})
            |=> $stable(bsr_q) && $stable(id_q) && $stable(byp_q);
    endproperty
    a_dr_hold: assert property (p_dr_hold) else $error("data register moved");

    property p_shift;
        @(posedge clk) disable iff (!rst_n)
        (ev.rise && st_q == TIS_SHIFT_IR) |=>
            st_q == ($past(ev.tms) ? TIS_EXIT1_IR : TIS_SHIFT_IR);
    endproperty
    a_shift: assert property (p_shift) else $error("shift-ir path");

    property p_capture;
        @(posedge clk) disable iff (!rst_n)
        (ev.rise && st_q == TIS_CAP_IR) |=> irs_q == `TIS_IR_CAPTURE;
    endproperty
    a_capture: assert property (p_capture) else $error("capture pattern");

    property p_upd_next;
        @(posedge clk) disable iff (!rst_n)
        (ev.rise && st_q == TIS_UPD_IR) |=>
            st_q == ($past(ev.tms) ? TIS_SEL_DR : TIS_IDLE);
    endproperty
    a_upd_next: assert property (p_upd_next) else $error("update-ir path");

    c_pause: cover property (@(posedge clk) disable iff (!rst_n)
        st_q == TIS_PAUSE_IR ##1 st_q == TIS_EXIT2_IR);
    c_resume: cover property (@(posedge clk) disable iff (!rst_n)
        st_q == TIS_EXIT2_IR ##1 st_q == TIS_SHIFT_IR);
    c_load: cover property (@(posedge clk) disable iff (!rst_n)
        ev.fall && st_q == TIS_UPD_IR);
endmodule
`default_nettype wire

//--- sim/test_tap_instruction_scan_tail.sv
`default_nettype none
`include "tis_params.svh"
module test_tap_instruction_scan_tail;
    timeunit 1ns;
    timeprecision 1ns;
    import tis_pkg::*;

    logic                  clk;
    logic                  rst_n;
    tis_pins_s             pins;
    logic [`TIS_BSR_W-1:0] bsr_pins;
    tis_state_e            state;
    logic [`TIS_IR_W-1:0]  instr;
    logic [`TIS_BSR_W-1:0] bsr_out;
    tis_state_e            m_state;
    logic [2:0]            m_sr;
    logic [2:0]            m_instr;
    logic [31:0]           m_dr;
    logic [7:0]            m_bsr;
    logic                  tdo;
    logic                  tdo_oe;
    int                    n_mismatch;
    int                    num_checks;
    integer                seed;
    logic [2:0]            codes[$];

    tis_tap dut (.clk(clk), .rst_n(rst_n), .pins(pins), .bsr_pins(bsr_pins), .tdo(tdo),
                 .tdo_oe(tdo_oe), .state(state), .instr(instr), .bsr_out(bsr_out));
    tis_tester tst (.clk(clk), .pins(pins));

    always #50 clk = ~clk;

    function automatic tis_state_e nxt(input tis_state_e s, input logic t);
        case (s)
            TIS_RESET:                return t ? TIS_RESET : TIS_IDLE;
            TIS_IDLE:                 return t ? TIS_SEL_DR : TIS_IDLE;
            TIS_SEL_DR:               return t ? TIS_SEL_IR : TIS_CAP_DR;
            TIS_SEL_IR:               return t ? TIS_RESET : TIS_CAP_IR;
            TIS_CAP_IR, TIS_SHIFT_IR: return t ? TIS_EXIT1_IR : TIS_SHIFT_IR;
            TIS_EXIT1_IR:             return t ? TIS_UPD_IR : TIS_PAUSE_IR;
            TIS_PAUSE_IR:             return t ? TIS_EXIT2_IR : TIS_PAUSE_IR;
            TIS_EXIT2_IR:             return t ? TIS_UPD_IR : TIS_SHIFT_IR;
            TIS_UPD_IR:               return t ? TIS_SEL_DR : TIS_IDLE;
            TIS_CAP_DR, TIS_SHIFT_DR: return t ? TIS_EXIT1_DR : TIS_SHIFT_DR;
            TIS_EXIT1_DR:             return t ? TIS_UPD_DR : TIS_PAUSE_DR;
            TIS_PAUSE_DR:             return t ? TIS_EXIT2_DR : TIS_PAUSE_DR;
            TIS_EXIT2_DR:             return t ? TIS_UPD_DR : TIS_SHIFT_DR;
            TIS_UPD_DR:               return t ? TIS_SEL_DR : TIS_IDLE;
            default:                  return s;
        endcase
    endfunction

    function automatic logic is_bsr(input logic [2:0] i);
        return i == `TIS_IR_EXTEST || i == `TIS_IR_SAMPLE;
    endfunction

    task automatic chk_state(input tis_state_e e, input tis_state_e g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error state expected %0d seen %0d", e, g);
        end
    endtask

    task automatic chk_vec(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one tck period; the model moves on the rise and latches on the fall
    task automatic step(input logic tms, input logic tdi);
        @(posedge clk);
        bsr_pins <= `TIS_BSR_W'($random(seed));
        tst.cyc(tms, tdi);
        if (m_state == TIS_CAP_IR) m_sr = `TIS_IR_CAPTURE;
        else if (m_state == TIS_SHIFT_IR) m_sr = {tdi, m_sr[2:1]};
        if (m_state == TIS_CAP_DR) begin
            if (is_bsr(m_instr)) m_dr = {24'h00_0000, bsr_pins};
            else if (m_instr == `TIS_IR_IDCODE) m_dr = `TIS_ID_VALUE;
            else m_dr = 32'h0000_0000;
        end else if (m_state == TIS_SHIFT_DR) begin
            if (is_bsr(m_instr)) m_dr = {24'h00_0000, tdi, m_dr[7:1]};
            else if (m_instr == `TIS_IR_IDCODE) m_dr = {tdi, m_dr[31:1]};
            else m_dr = {31'h0000_0000, tdi};
        end
        m_state = nxt(m_state, tms);
        #1;
        chk_state(m_state, state);
        if (m_state == TIS_UPD_IR) m_instr = m_sr;
        if (m_state == TIS_RESET) m_instr = `TIS_IR_IDCODE;
        if (m_state == TIS_UPD_DR && is_bsr(m_instr)) m_bsr = m_dr[7:0];
        repeat (4) @(posedge clk);
        #1;
        chk_vec("instr", 8'(m_instr), 8'(instr));
        chk_vec("bsr_out", m_bsr, bsr_out);
        chk_vec("tdo_oe", 8'(m_state inside {TIS_SHIFT_IR, TIS_SHIFT_DR}), 8'(tdo_oe));
        if (m_state == TIS_SHIFT_IR) chk_vec("tdo", 8'(m_sr[0]), 8'(tdo));
        if (m_state == TIS_SHIFT_DR) chk_vec("tdo", 8'(m_dr[0]), 8'(tdo));
    endtask

    // path 0 exits straight, 1 goes through pause, 2 pauses then resumes shifting
    task automatic scan(input logic [2:0] code, input int path, input int nsh,
                        input logic tms_out);
        if (m_state != TIS_SEL_DR) step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b0);
        step(1'b0, 1'b1);
        for (int k = 0; k < nsh; k++) step(k == nsh - 1, code[k] ^ (path == 2));
        if (path > 0) begin
            repeat (1 + path) step(1'b0, 1'($random(seed)));
            step(1'b1, 1'($random(seed)));
            if (path == 2) begin
                step(1'b0, 1'b0);
                for (int k = 0; k < 3; k++) step(k == 2, code[k]);
            end
        end
        step(1'b1, 1'($random(seed)));
        step(tms_out, 1'($random(seed)));
    endtask

    // data scan through whatever register the active instruction picks, with one pause
    task automatic dscan(input int nsh, input logic tms_out);
        if (m_state != TIS_SEL_DR) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        for (int k = 0; k < nsh; k++) step(k == nsh - 1, 1'($random(seed)));
        step(1'b0, 1'($random(seed)));
        step(1'b1, 1'($random(seed)));
        step(1'b1, 1'($random(seed)));
        step(tms_out, 1'($random(seed)));
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        bsr_pins = '0;
        seed = 32'h3b0e_f96b;
        n_mismatch = 0;
        num_checks = 0;
        m_state = TIS_RESET;
        m_sr = `TIS_IR_CAPTURE;
        m_instr = `TIS_IR_IDCODE;
        m_dr = 32'h0000_0000;
        m_bsr = 8'h00;
        codes = '{`TIS_IR_EXTEST, `TIS_IR_SAMPLE, `TIS_IR_IDCODE, `TIS_IR_BYPASS,
                  3'h5, 3'h3};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk_state(TIS_RESET, state);
        chk_vec("instr", 8'(`TIS_IR_IDCODE), 8'(instr));
        step(1'b0, 1'b1);
        // the last code shifts a single bit before its pause, then the resumed shift loads all three bits
        foreach (codes[i]) begin
            scan(codes[i], i % 3, (i == 5) ? 1 : 3, 1'(i % 2));
            dscan(9, 1'(i / 3));
        end
        repeat (5) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        scan(3'h6, 1, 2, 1'b0);
        // reset in the middle of a pause must bring back the default instruction
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        m_state = TIS_RESET;
        m_sr = `TIS_IR_CAPTURE;
        m_instr = `TIS_IR_IDCODE;
        m_bsr = 8'h00;
        repeat (2) @(posedge clk);
        #1;
        chk_state(TIS_RESET, state);
        chk_vec("instr", 8'(`TIS_IR_IDCODE), 8'(instr));
        chk_vec("bsr_out", 8'h00, bsr_out);
        chk_vec("tdo_oe", 8'h00, 8'(tdo_oe));
        step(1'b0, 1'b0);
        scan(`TIS_IR_SAMPLE, 2, 3, 1'b0);
        dscan(9, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire

//--- sim/tis_tester.sv
`default_nettype none
module tis_tester (
    input  wire logic               clk,
    output var  tis_pkg::tis_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ns;
    import tis_pkg::*;

    initial begin
        pins = '0;
    end

    // tck idles low between frames; tms and tdi settle three clk cycles before the rise,
    // since the device samples them through the same sync delay as tck
    task automatic cyc(input logic tms, input logic tdi);
        @(posedge clk);
        pins.tms <= tms;
        pins.tdi <= tdi;
        repeat (3) @(posedge clk);
        pins.tck <= 1'b1;
        repeat (4) @(posedge clk);
        pins.tck <= 1'b0;
    endtask
endmodule
`default_nettype wire
